// File: logic/tws_top.sv
// Two-wire synchronous serial channel with register port
`timescale 1ns/1ps
`include "tws_defines.svh"

module tws_top (
   // Clock and reset
   input wire logic i_ref_clk,
   input wire logic i_resetn,
   // Register port
   input wire logic [15:0] i_reg_addr,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   input wire tws_pkg::tws_byte_t i_reg_wdata,
   output tws_pkg::tws_byte_t o_reg_rdata,
   // Transfer flag
   input wire logic i_done_clear,
   output logic o_transfer_done_flag,
   // Clock sources and port latches
   input wire logic i_timer_two_output,
   input wire logic i_prescaler_select,
   input wire logic i_clock_pin_latch,
   input wire logic i_clock_pin_direction,
   input wire logic i_pin_a_port_latch,
   input wire logic i_pin_b_port_latch,
   // Serial clock pin
   input wire logic i_serial_clock_pin,
   output logic o_serial_clock_pin,
   output logic o_serial_clock_pin_oe_n,
   // Data pins
   input wire logic i_data_pin_a,
   output logic o_data_pin_a,
   output logic o_data_pin_a_oe_n,
   input wire logic i_data_pin_b,
   output logic o_data_pin_b,
   output logic o_data_pin_b_oe_n,
   // Received bytes
   input wire logic i_rx_ready,
   output logic o_rx_valid,
   output tws_pkg::tws_byte_t o_rx_data
);
   import tws_pkg::*;

   function automatic logic tws_two_wire(input tws_byte_t m);
      tws_two_wire = m[`TWS_BIT_MODE_HI] & m[`TWS_BIT_MODE_MID];
   endfunction : tws_two_wire

   tws_byte_t serial_mode_control;
   tws_byte_t bus_signal_control;
   tws_byte_t interrupt_timing_select;
   tws_byte_t shift_register;
   tws_byte_t slave_address_register;
   tws_state_t state;
   tws_state_t next_state;
   logic [3:0] bit_count;
   logic [2:0] sync1;
   logic [2:0] sync2;
   logic output_latch;
   logic sck_int;
   logic sck_prev;
   logic src_prev;
   logic channel_enable;
   logic two_wire;
   logic ext_clk;
   logic use_pin_a;
   logic data_in;
   logic src_sel;
   logic sck_level;
   logic sck_fall;
   logic sck_rise;
   logic wr_shift;
   logic start_ok;
   logic address_match_flag;
   logic clock_level_flag;

   tws_stream_if #(.WIDTH(`TWS_BYTE_W)) rx_in ();
   tws_stream_if #(.WIDTH(`TWS_BYTE_W)) rx_out ();

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         sync1 <= 3'h7;
         sync2 <= 3'h7;
      end else begin
         sync1 <= {i_data_pin_b, i_data_pin_a, i_serial_clock_pin};
         sync2 <= sync1;
      end
   end

   // ----------------------------------------
   // Decode
   // ----------------------------------------
   assign channel_enable = serial_mode_control[`TWS_BIT_ENABLE];
   assign two_wire = tws_two_wire(serial_mode_control);
   assign ext_clk = ~serial_mode_control[`TWS_BIT_CLK_HI];
   assign use_pin_a = serial_mode_control[`TWS_BIT_PIN_SEL];
   assign data_in = use_pin_a ? sync2[1] : sync2[2];
   assign src_sel = serial_mode_control[`TWS_BIT_CLK_LO] ?
                    i_prescaler_select : i_timer_two_output;
   assign sck_level = ext_clk ? sync2[0] : sck_int;
   assign sck_fall = sck_prev & ~sck_level;
   assign sck_rise = ~sck_prev & sck_level;
   assign wr_shift = i_reg_wr && (i_reg_addr == `TWS_ADDR_SHIFT);
   assign start_ok = wr_shift && channel_enable && two_wire && (state == TWS_IDLE)
                     && rx_in.ready && (!ext_clk || sync2[0]);
   assign address_match_flag = channel_enable &&
                               (slave_address_register == shift_register);
   assign clock_level_flag = channel_enable & sync2[0];

   // ----------------------------------------
   // Serial clock
   // ----------------------------------------
   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         sck_int <= 1'b1;
         sck_prev <= 1'b1;
         src_prev <= 1'b0;
      end else begin
         src_prev <= src_sel;
         sck_prev <= sck_level;
         if (state != TWS_SHIFT) begin
            sck_int <= 1'b1;
         end else if (src_sel && !src_prev) begin
            sck_int <= ~sck_int;
         end
      end
   end

   // ----------------------------------------
   // Transfer sequencer
   // ----------------------------------------
   always_comb begin
      next_state = state;
      case (state)
         TWS_IDLE: begin
            if (start_ok) begin
               next_state = TWS_SHIFT;
            end
         end
         TWS_SHIFT: begin
            if (!channel_enable || !two_wire) begin
               next_state = TWS_IDLE;
            end else if (sck_rise && bit_count == `TWS_LAST_BIT) begin
               next_state = TWS_PUSH;
            end
         end
         TWS_PUSH: begin
            next_state = TWS_IDLE;
         end
         default: begin
            next_state = TWS_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         state <= TWS_IDLE;
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         bit_count <= 4'h0;
      end else if (state != TWS_SHIFT) begin
         bit_count <= 4'h0;
      end else if (sck_rise) begin
         bit_count <= bit_count + 4'h1;
      end
   end

   // ----------------------------------------
   // Shift register and output latch
   // ----------------------------------------
   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         shift_register <= `TWS_RST_BYTE;
      end else if (state == TWS_IDLE && wr_shift) begin
         shift_register <= i_reg_wdata;
      end else if (state == TWS_SHIFT && sck_fall) begin
         shift_register <= {shift_register[6:0], 1'b0};
      end else if (state == TWS_SHIFT && sck_rise) begin
         shift_register[0] <= data_in;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         output_latch <= `TWS_RST_LATCH;
      end else if (bus_signal_control[`TWS_BIT_SET_TRIG]) begin
         output_latch <= 1'b1;
      end else if (bus_signal_control[`TWS_BIT_CLR_TRIG]) begin
         output_latch <= 1'b0;
      end else if (state == TWS_SHIFT && sck_fall) begin
         output_latch <= shift_register[7];
      end
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         serial_mode_control <= `TWS_RST_BYTE;
      end else if (i_reg_wr && i_reg_addr == `TWS_ADDR_MODE) begin
         serial_mode_control <= i_reg_wdata & 8'hBF;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         bus_signal_control <= `TWS_RST_BYTE;
      end else if (i_reg_wr && i_reg_addr == `TWS_ADDR_BUSCTL) begin
         bus_signal_control <= {i_reg_wdata[7:2],
                                i_reg_wdata[1:0] & {2{channel_enable}}};
      end else begin
         bus_signal_control[1:0] <= 2'h0;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         interrupt_timing_select <= `TWS_RST_BYTE;
      end else if (i_reg_wr && i_reg_addr == `TWS_ADDR_TIMING) begin
         interrupt_timing_select <= i_reg_wdata & 8'hBF;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         slave_address_register <= `TWS_RST_BYTE;
      end else if (i_reg_wr && i_reg_addr == `TWS_ADDR_SVA) begin
         slave_address_register <= i_reg_wdata;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_reg_rdata <= `TWS_RST_BYTE;
      end else if (i_reg_rd) begin
         case (i_reg_addr)
            `TWS_ADDR_MODE: begin
               o_reg_rdata <= {serial_mode_control[7], address_match_flag,
                               serial_mode_control[5:0]};
            end
            `TWS_ADDR_BUSCTL: begin
               o_reg_rdata <= bus_signal_control;
            end
            `TWS_ADDR_TIMING: begin
               o_reg_rdata <= {interrupt_timing_select[7], clock_level_flag,
                               interrupt_timing_select[5:0]};
            end
            `TWS_ADDR_SHIFT: begin
               o_reg_rdata <= shift_register;
            end
            `TWS_ADDR_SVA: begin
               o_reg_rdata <= slave_address_register;
            end
            default: begin
               o_reg_rdata <= `TWS_RST_BYTE;
            end
         endcase
      end
   end

   // ----------------------------------------
   // Completion flag
   // ----------------------------------------
   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_transfer_done_flag <= 1'b0;
      end else if (state == TWS_PUSH && !serial_mode_control[`TWS_BIT_WAKE]) begin
         o_transfer_done_flag <= 1'b1;
      end else if (i_done_clear) begin
         o_transfer_done_flag <= 1'b0;
      end
   end

   // ----------------------------------------
   // Pins
   // ----------------------------------------
   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_data_pin_a <= 1'b0;
         o_data_pin_a_oe_n <= 1'b1;
         o_data_pin_b <= 1'b0;
         o_data_pin_b_oe_n <= 1'b1;
         o_serial_clock_pin <= 1'b0;
         o_serial_clock_pin_oe_n <= 1'b1;
      end else begin
         if (two_wire && use_pin_a) begin
            o_data_pin_a <= 1'b0;
            o_data_pin_a_oe_n <= output_latch;
         end else begin
            o_data_pin_a <= i_pin_a_port_latch;
            o_data_pin_a_oe_n <= 1'b0;
         end
         if (two_wire && !use_pin_a) begin
            o_data_pin_b <= 1'b0;
            o_data_pin_b_oe_n <= output_latch;
         end else begin
            o_data_pin_b <= i_pin_b_port_latch;
            o_data_pin_b_oe_n <= 1'b0;
         end
         o_serial_clock_pin <= 1'b0;
         o_serial_clock_pin_oe_n <= ext_clk || i_clock_pin_direction ||
            ((state == TWS_SHIFT) ? sck_int : i_clock_pin_latch);
      end
   end

   // ----------------------------------------
   // Receive buffer
   // ----------------------------------------
   assign rx_in.valid = (state == TWS_PUSH);
   assign rx_in.data = shift_register;
   assign rx_out.ready = !o_rx_valid || i_rx_ready;

   tws_fifo #(.WIDTH(`TWS_BYTE_W), .DEPTH(`TWS_FIFO_DEPTH)) u_fifo (
      .i_ref_clk(i_ref_clk),
      .i_resetn(i_resetn),
      .s_in(rx_in.snk),
      .s_out(rx_out.src)
   );

   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_rx_valid <= 1'b0;
         o_rx_data <= `TWS_RST_BYTE;
      end else if (rx_out.ready) begin
         o_rx_valid <= rx_out.valid;
         if (rx_out.valid) begin
            o_rx_data <= rx_out.data;
         end
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_resetn);

   AST_MATCH_OFF: assert property (
      (i_reg_rd && i_reg_addr == `TWS_ADDR_MODE && !channel_enable)
      |=> !o_reg_rdata[`TWS_BIT_MATCH])
      else $error("match flag read high while disabled");
   AST_MATCH_ON: assert property (
      (i_reg_rd && i_reg_addr == `TWS_ADDR_MODE && channel_enable &&
       slave_address_register == shift_register) |=> o_reg_rdata[`TWS_BIT_MATCH])
      else $error("match flag missing on equal bytes");
   AST_SET_TRIG: assert property (
      (i_reg_wr && i_reg_addr == `TWS_ADDR_BUSCTL && i_reg_wdata[0] && channel_enable)
      |=> ##1 (output_latch && bus_signal_control[`TWS_BIT_SET_TRIG] == 1'b0))
      else $error("set trigger did not raise latch");
   AST_CLR_TRIG: assert property (
      (i_reg_wr && i_reg_addr == `TWS_ADDR_BUSCTL && i_reg_wdata[1:0] == 2'h2
       && channel_enable) |=> ##1 !output_latch)
      else $error("clear trigger did not lower latch");
   AST_TRIG_HELD: assert property (
      !channel_enable |=> bus_signal_control[1:0] == 2'h0)
      else $error("trigger bit kept while disabled");
   AST_CLK_LEVEL: assert property (
      (i_reg_rd && i_reg_addr == `TWS_ADDR_TIMING && !channel_enable)
      |=> !o_reg_rdata[`TWS_BIT_CLK_LEVEL])
      else $error("clock level flag high while disabled");
   AST_NO_START: assert property (
      (state == TWS_IDLE && !channel_enable) |=> state == TWS_IDLE)
      else $error("transfer began while disabled");
   AST_EIGHTH: assert property (
      (state == TWS_SHIFT && channel_enable && two_wire && sck_rise &&
       bit_count == `TWS_LAST_BIT) |=> state == TWS_PUSH ##1 state == TWS_IDLE)
      else $error("no stop after eighth bit");
   AST_FLAG: assert property (
      (state == TWS_PUSH && !serial_mode_control[`TWS_BIT_WAKE]) |=> o_transfer_done_flag)
      else $error("completion flag not set");
   AST_MSB: assert property (
      (state == TWS_SHIFT && sck_fall && bus_signal_control[1:0] == 2'h0)
      |=> output_latch == $past(shift_register[7]))
      else $error("output latch not loaded with top bit");
   AST_EXT_CLK: assert property (
      ext_clk |=> o_serial_clock_pin_oe_n)
      else $error("clock pin driven with external clock");

   COV_START: cover property (state == TWS_IDLE && start_ok);
   COV_DONE: cover property (state == TWS_PUSH);
   COV_FULL: cover property (!rx_in.ready);
   COV_MATCH: cover property (i_reg_rd && address_match_flag);
endmodule : tws_top

// File: common/tws_defines.svh
// Register offsets, field positions, reset values and counts
`ifndef TWS_DEFINES_SVH
`define TWS_DEFINES_SVH
`define TWS_ADDR_MODE 16'hFF60
`define TWS_ADDR_BUSCTL 16'hFF61
`define TWS_ADDR_TIMING 16'hFF63
`define TWS_ADDR_SHIFT 16'hFF1F
`define TWS_ADDR_SVA 16'hFF1D
`define TWS_RST_BYTE 8'h00
`define TWS_RST_LATCH 1'h1
`define TWS_BIT_ENABLE 7
`define TWS_BIT_MATCH 6
`define TWS_BIT_WAKE 5
`define TWS_BIT_MODE_HI 4
`define TWS_BIT_MODE_MID 3
`define TWS_BIT_PIN_SEL 2
`define TWS_BIT_CLK_HI 1
`define TWS_BIT_CLK_LO 0
`define TWS_BIT_SET_TRIG 0
`define TWS_BIT_CLR_TRIG 1
`define TWS_BIT_CLK_LEVEL 6
`define TWS_LAST_BIT 4'h7
`define TWS_FIFO_DEPTH 8
`define TWS_BYTE_W 8
`endif

// File: common/tws_pkg.sv
// Types shared by the two-wire serial channel
package tws_pkg;
   typedef logic [7:0] tws_byte_t;
   typedef enum logic [2:0] {
      TWS_IDLE = 3'b001,
      TWS_SHIFT = 3'b010,
      TWS_PUSH = 3'b100
   } tws_state_t;
endpackage : tws_pkg

// File: common/tws_stream_if.sv
// Valid/ready byte stream between channel and buffer
`timescale 1ns/1ps
interface tws_stream_if #(parameter int WIDTH = 8);
   logic valid;
   logic ready;
   logic [WIDTH-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface : tws_stream_if

// File: logic/tws_fifo.sv
// Receive byte buffer with valid/ready on both sides
`timescale 1ns/1ps
module tws_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input wire logic i_ref_clk,
   input wire logic i_resetn,
   // Stream ports
   tws_stream_if.snk s_in,
   tws_stream_if.src s_out
);
   import tws_pkg::*;
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL = DEPTH[AW:0];
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0] count;
   logic push;
   logic pop;

   assign push = s_in.valid & s_in.ready;
   assign pop = s_out.valid & s_out.ready;
   assign s_in.ready = (count != FULL);
   assign s_out.valid = (count != '0);
   assign s_out.data = mem[rd_ptr];

   // ----------------------------------------
   // Storage
   // ----------------------------------------
   always_ff @(posedge i_ref_clk) begin
      if (push) begin
         mem[wr_ptr] <= s_in.data;
      end
   end

   // ----------------------------------------
   // Pointers and fill level
   // ----------------------------------------
   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         if (push) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
         if (push && !pop) begin
            count <= count + 1'b1;
         end else if (pop && !push) begin
            count <= count - 1'b1;
         end
      end
   end
endmodule : tws_fifo

// File: tb/tws_peer.sv
// Far-side clock master on the two-wire bus
`timescale 1ns/1ps
module tws_peer (
   // Clock
   input wire logic i_ref_clk,
   // Bus lines, open drain: 1 pulls the line low
   input wire logic i_data_line,
   output logic o_clk_low,
   output logic o_data_low
);
   initial begin
      o_clk_low = 1'b0;
      o_data_low = 1'b0;
   end
   // One byte, MSB first, half period in cycles
   task automatic xfer(input logic [7:0] tx, input int half, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         @(posedge i_ref_clk);
         o_clk_low <= 1'b1;
         repeat (half / 2) @(posedge i_ref_clk);
         o_data_low <= ~tx[i];
         repeat (half) @(posedge i_ref_clk);
         o_clk_low <= 1'b0;
         repeat (half) @(posedge i_ref_clk);
         #1;
         rx[i] = i_data_line;
      end
      @(posedge i_ref_clk);
      o_data_low <= 1'b0;
   endtask : xfer
endmodule : tws_peer

// File: tb/two_wire_sync_serial_tb_top.sv
// Self-checking bench for the two-wire serial channel
`timescale 1ns/1ps
`include "tws_defines.svh"
module two_wire_sync_serial_tb_top;
   import tws_pkg::*;
   logic clk, rstn, wr, rd, done_clr, pa_latch, rx_ready, done_flag, sck_o, sck_oe_n;
   logic a_o, a_oe_n, b_o, b_oe_n, rx_valid, peer_clk_low, peer_data_low;
   logic tmr, sck_dir, sck_latch;
   logic [15:0] addr;
   tws_byte_t wdata, rdata, rx_data, got, lvl;
   wire logic sck_line;
   wire logic b_line;
   wire logic a_line;
   int miscompares;
   int n_compared;
   assign sck_line = !(peer_clk_low || (!sck_oe_n && !sck_o));
   assign b_line = !(peer_data_low || (!b_oe_n && !b_o));
   assign a_line = a_oe_n ? 1'b1 : a_o;
   tws_peer u_peer (.i_ref_clk(clk), .i_data_line(b_line), .o_clk_low(peer_clk_low),
      .o_data_low(peer_data_low));
   tws_top DUT (.i_ref_clk(clk), .i_resetn(rstn), .i_reg_addr(addr), .i_reg_wr(wr),
      .i_reg_rd(rd), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_done_clear(done_clr),
      .o_transfer_done_flag(done_flag), .i_timer_two_output(tmr),
      .i_prescaler_select(1'b0), .i_clock_pin_latch(sck_latch),
      .i_clock_pin_direction(sck_dir),
      .i_pin_a_port_latch(pa_latch), .i_pin_b_port_latch(1'b1),
      .i_serial_clock_pin(sck_line), .o_serial_clock_pin(sck_o),
      .o_serial_clock_pin_oe_n(sck_oe_n), .i_data_pin_a(a_line), .o_data_pin_a(a_o),
      .o_data_pin_a_oe_n(a_oe_n), .i_data_pin_b(b_line), .o_data_pin_b(b_o),
      .o_data_pin_b_oe_n(b_oe_n), .i_rx_ready(rx_ready), .o_rx_valid(rx_valid),
      .o_rx_data(rx_data));
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic print_verdict;
      $display("compared %0d mismatched %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : print_verdict
   task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk
   task automatic wr_reg(input logic [15:0] a, input tws_byte_t d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg
   task automatic rd_chk(input string name, input logic [15:0] a, input tws_byte_t exp);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(posedge clk);
      #1;
      chk(name, rdata, exp);
   endtask : rd_chk
   task automatic wait_flag;
      for (int i = 0; i < 60; i++) begin
         @(posedge clk);
         #1;
         if (done_flag === 1'b1) begin
            return;
         end
      end
      miscompares++;
      print_verdict();
   endtask : wait_flag
   task automatic pop(input tws_byte_t exp);
      for (int i = 0; i < 60 && rx_valid !== 1'b1; i++) begin
         @(posedge clk);
         #1;
      end
      if (rx_valid !== 1'b1) begin
         miscompares++;
         print_verdict();
      end else begin
         chk("rx_data", rx_data, exp);
         @(posedge clk);
         rx_ready <= 1'b1;
         @(posedge clk);
         rx_ready <= 1'b0;
         repeat (2) @(posedge clk);
         #1;
      end
   endtask : pop
   task automatic clear_flag;
      @(posedge clk);
      done_clr <= 1'b1;
      @(posedge clk);
      done_clr <= 1'b0;
   endtask : clear_flag
   // ----------------------------------------
   // Sequence
   // ----------------------------------------
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   initial begin
      rstn = 1'b0;
      wr = 1'b0;
      rd = 1'b0;
      addr = 16'h0000;
      wdata = 8'h00;
      done_clr = 1'b0;
      pa_latch = 1'b0;
      rx_ready = 1'b0;
      tmr = 1'b0;
      sck_dir = 1'b1;
      sck_latch = 1'b1;
      miscompares = 0;
      n_compared = 0;
      repeat (3) @(posedge clk);
      rstn <= 1'b1;
      rd_chk("mode_rst", `TWS_ADDR_MODE, 8'h00);
      rd_chk("busctl_rst", `TWS_ADDR_BUSCTL, 8'h00);
      rd_chk("timing_rst", `TWS_ADDR_TIMING, 8'h00);
      rd_chk("unmapped", 16'hFF00, 8'h00);
      wr_reg(`TWS_ADDR_BUSCTL, 8'h03);
      rd_chk("trig_off", `TWS_ADDR_BUSCTL, 8'h00);
      wr_reg(`TWS_ADDR_SVA, 8'h5A);
      wr_reg(`TWS_ADDR_MODE, 8'hD8);
      pa_latch <= 1'b1;
      rd_chk("mode_on", `TWS_ADDR_MODE, 8'h98);
      chk("pin_a_free", {6'h00, a_oe_n, a_line}, 8'h01);
      wr_reg(`TWS_ADDR_BUSCTL, 8'h02);
      rd_chk("clr_self", `TWS_ADDR_BUSCTL, 8'h00);
      chk("latch_low", {7'h00, b_line}, 8'h00);
      wr_reg(`TWS_ADDR_BUSCTL, 8'h01);
      rd_chk("set_self", `TWS_ADDR_BUSCTL, 8'h00);
      chk("latch_high", {7'h00, b_line}, 8'h01);
      // Transmit, wake bit kept zero
      wr_reg(`TWS_ADDR_SVA, 8'hA5);
      wr_reg(`TWS_ADDR_SHIFT, 8'hA5);
      u_peer.xfer(8'hFF, 10, got);
      chk("tx_byte", got, 8'hA5);
      wait_flag();
      chk("done_tx", {7'h00, done_flag}, 8'h01);
      rd_chk("tx_echo", `TWS_ADDR_SHIFT, 8'hA5);
      rd_chk("tx_ok", `TWS_ADDR_MODE, 8'hD8);
      chk("sck_free", {7'h00, sck_oe_n}, 8'h01);
      clear_flag();
      // Receive, slow partner
      wr_reg(`TWS_ADDR_SHIFT, 8'hFF);
      u_peer.xfer(8'h3C, 16, got);
      chk("rx_line", got, 8'h3C);
      wait_flag();
      rd_chk("rx_byte", `TWS_ADDR_SHIFT, 8'h3C);
      rd_chk("rx_err", `TWS_ADDR_MODE, 8'h98);
      clear_flag();
      pop(8'hA5);
      pop(8'h3C);
      // Disabled channel
      wr_reg(`TWS_ADDR_SVA, 8'h3C);
      wr_reg(`TWS_ADDR_MODE, 8'h18);
      wr_reg(`TWS_ADDR_TIMING, 8'hE0);
      rd_chk("match_off", `TWS_ADDR_MODE, 8'h18);
      rd_chk("level_off", `TWS_ADDR_TIMING, 8'hA0);
      wr_reg(`TWS_ADDR_SHIFT, 8'h00);
      wr_reg(`TWS_ADDR_MODE, 8'h98);
      u_peer.xfer(8'hFF, 10, got);
      repeat (20) @(posedge clk);
      #1;
      chk("no_start", {6'h00, done_flag, rx_valid}, 8'h00);
      rd_chk("held", `TWS_ADDR_SHIFT, 8'h00);
      // Timer clock, clock pin in output mode
      @(posedge clk);
      sck_dir <= 1'b0;
      sck_latch <= 1'b0;
      repeat (3) @(posedge clk);
      #1;
      chk("sck_ext", {7'h00, sck_line}, 8'h01);
      wr_reg(`TWS_ADDR_MODE, 8'h9A);
      repeat (3) @(posedge clk);
      #1;
      chk("sck_port_low", {7'h00, sck_line}, 8'h00);
      @(posedge clk);
      sck_latch <= 1'b1;
      repeat (3) @(posedge clk);
      #1;
      chk("sck_port_high", {7'h00, sck_line}, 8'h01);
      wr_reg(`TWS_ADDR_SHIFT, 8'h96);
      for (int i = 0; i < 16; i++) begin
         @(posedge clk);
         tmr <= 1'b1;
         repeat (4) @(posedge clk);
         tmr <= 1'b0;
         repeat (4) @(posedge clk);
         #1;
         if (i % 2 == 0) begin
            lvl = {lvl[6:0], sck_line};
         end else begin
            got = {got[6:0], b_line};
         end
      end
      chk("int_sck", lvl, 8'h00);
      chk("int_tx", got, 8'h96);
      wait_flag();
      rd_chk("int_echo", `TWS_ADDR_SHIFT, 8'h96);
      pop(8'h96);
      print_verdict();
   end
endmodule : two_wire_sync_serial_tb_top
